// [tb_top.sv]
/*
  Self-checking bench for the triggered PWM timer over classic Wishbone.
  Assumes the far-side source flips pins; both edges are selected except in the rising-only trigger test.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import tpwm_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        trq = 1'b0, erq = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd = '0, q;
  wire logic [31:0] rd;
  wire logic   ack, trig, evt, tog, pwm, pirq, dirq;
  int n_errors = 0, num_checks = 0, nper = 0, n0, per, hi, dq;
  logic [7:0]  ofs [8] = '{OFS_RUN, OFS_MODE, OFS_EDGE, OFS_PERIOD,
                           OFS_DUTY, OFS_COUNT, OFS_STATUS, 8'h1c};
  logic [15:0] rv [8] = '{CMP_RST, CMP_RST, CMP_RST, CMP_RST, CMP_RST,
                          CNT_IDLE, CMP_RST, CMP_RST};
  int tp [4] = '{3, 5, 5, 4};
  int td [4] = '{2, 2, 1, 7};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (pirq === 1'b1) nper <= nper + 1;
  tpwm_timer #(.COUNT_DIV(1)) dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .trig_in(trig),
    .event_in(evt), .toggle_output(tog), .pwm_output(pwm),
    .period_match_irq(pirq), .duty_match_irq(dirq));
  tpwm_far_end far_u (.clk(clk), .rst(rst), .trig_req(trq), .evt_req(erq),
    .trig_in(trig), .event_in(evt));
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // Request held until ack is sampled, then released for a cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    sel <= 4'hf;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 20) begin
      n_errors++;
      summarize();
    end
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q[15:0], e)
  endtask : chk_rd
  task automatic wfor(input int k);
    int i;
    i = 0;
    while (((k == 0) ? pwm : dirq) !== 1'b1 && i < 500) begin
      @(posedge clk);
      i++;
    end
    if (i >= 500) begin
      n_errors++;
      summarize();
    end
  endtask : wfor
  // One flip of the event pin per request, so one edge each
  task automatic ev(input int n);
    repeat (n) begin
      erq <= 1'b1;
      @(posedge clk);
      erq <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : ev
  // One flip of the trigger pin, then time for the edge to act
  task automatic tpulse;
    trq <= 1'b1;
    @(posedge clk);
    trq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tpulse
  // One full counter cycle, from one period match to the next
  task automatic meas;
    int i;
    per = 0;
    hi = 0;
    dq = 0;
    i = 0;
    while (pirq !== 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    do begin
      per++;
      hi += (pwm === 1'b1);
      dq += (dirq === 1'b1);
      @(posedge clk);
    end while (pirq !== 1'b1 && per < 200);
    if (i >= 200 || per >= 200) begin
      n_errors++;
      summarize();
    end
  endtask : meas
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ofs[i]) chk_rd(ofs[i], rv[i]);
    wr(8'h1c, 32'hffff);
    chk_rd(8'h1c, 16'h0000);
    wr(OFS_EDGE, 32'hf);
    chk_rd(OFS_EDGE, 16'h000f);
    wr(OFS_PERIOD, 32'd20);
    wr(OFS_DUTY, 32'd10);
    wr(OFS_MODE, 32'(MODE_TRIG));
    wr(OFS_RUN, 32'h1);
    chk_rd(OFS_COUNT, CNT_IDLE);
    `CHK(pwm, 1'b0)
    trq <= 1'b1;
    @(posedge clk);
    trq <= 1'b0;
    wfor(0);
    `CHK(tog, 1'b1)
    wfor(1);
    `CHK(pwm, 1'b0)
    wr(OFS_MODE, 32'(MODE_TRIG) | 32'h40);
    `CHK(pwm, 1'b1)
    `CHK(tog, 1'b0)
    meas();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PERIOD, 32'(tp[i]));
      wr(OFS_DUTY, 32'(td[i]));
      meas();
      `CHK(per, tp[i] + 1)
      `CHK(hi, (td[i] > tp[i]) ? tp[i] + 1 : td[i])
      `CHK(dq, (td[i] > tp[i]) ? 0 : 1)
    end
    wr(OFS_PERIOD, 32'd2);
    meas();
    `CHK(per, 5)
    wr(OFS_DUTY, 32'd1);
    meas();
    `CHK(per, 3)
    wr(OFS_RUN, 32'h0);
    `CHK(pwm, 1'b0)
    chk_rd(OFS_COUNT, CNT_IDLE);
    wr(OFS_PERIOD, 32'd2);
    wr(OFS_MODE, 32'(MODE_EVENT));
    wr(OFS_RUN, 32'h1);
    ev(2);
    chk_rd(OFS_COUNT, 16'h0002);
    // A trigger edge in event count mode must leave the counter alone
    tpulse();
    chk_rd(OFS_COUNT, 16'h0002);
    n0 = nper;
    ev(1);
    `CHK(nper, n0 + 1)
    chk_rd(OFS_COUNT, CNT_ZERO);
    wr(OFS_PERIOD, 32'd10);
    ev(2);
    wr(OFS_PERIOD, 32'd3);
    ev(2);
    chk_rd(OFS_COUNT, CNT_ZERO);
    `CHK(nper, n0 + 2)
    wr(OFS_PERIOD, 32'd10);
    ev(6);
    wr(OFS_PERIOD, 32'd2);
    ev(3);
    chk_rd(OFS_COUNT, 16'h0009);
    `CHK(nper, n0 + 2)
    // Trigger mode counted by event edges, trigger on rising edge only
    wr(OFS_RUN, 32'h0);
    wr(OFS_EDGE, 32'hd);
    wr(OFS_PERIOD, 32'd3);
    wr(OFS_DUTY, 32'd2);
    wr(OFS_MODE, 32'(MODE_TRIG) | 32'h20);
    wr(OFS_RUN, 32'h1);
    chk_rd(OFS_STATUS, 16'h0009);
    tpulse();
    ev(2);
    chk_rd(OFS_COUNT, 16'h0002);
    `CHK(pwm, 1'b0)
    chk_rd(OFS_STATUS, 16'h0005);
    // The pin now falls, which is not the selected edge
    tpulse();
    chk_rd(OFS_COUNT, 16'h0002);
    wr(OFS_MODE, 32'(MODE_TRIG) | 32'h60);
    `CHK(pwm, 1'b1)
    chk_rd(OFS_MODE, 16'h0022);
    chk_rd(OFS_COUNT, CNT_ZERO);
    chk_rd(OFS_STATUS, 16'h0003);
    n0 = nper;
    ev(4);
    `CHK(nper, n0 + 1)
    `CHK(pwm, 1'b1)
    chk_rd(OFS_STATUS, 16'h0002);
    // Reset in mid-run, held for two edges
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(pwm, 1'b0)
    `CHK(tog, 1'b0)
    chk_rd(OFS_COUNT, CNT_IDLE);
    chk_rd(OFS_MODE, 16'h0000);
    chk_rd(OFS_STATUS, 16'h0000);
    summarize();
  end
endmodule : tb_top
`default_nettype wire

// [tpwm_checker.sv]
/*
  Port-level assertions for the triggered PWM timer channel.
  Assumes one clock, clk, and a synchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module tpwm_checker (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [tpwm_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [tpwm_pkg::WB_DW-1:0] wb_dat_i,
  input wire logic [tpwm_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       trig_in,
  input wire logic                       event_in,
  input wire logic                       toggle_output,
  input wire logic                       pwm_output,
  input wire logic                       period_match_irq,
  input wire logic                       duty_match_irq
);
  import tpwm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  property p_ack_lat; req |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("ack not one cycle after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_unmapped; req && !wb_we_i && wb_adr_i > 8'h1b |=> wb_dat_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_est_zero; req && !wb_we_i && wb_adr_i == OFS_MODE
    |=> !wb_dat_o[EST_BIT]; endproperty
  a_est_zero: assert property (p_est_zero)
    else $error("soft trigger bit reads one");
  property p_duty_low; duty_match_irq |-> !pwm_output; endproperty
  a_duty_low: assert property (p_duty_low)
    else $error("pwm high at duty match");
  property p_tog_pwm; $rose(toggle_output) |-> pwm_output; endproperty
  a_tog_pwm: assert property (p_tog_pwm)
    else $error("toggle rose without pwm high");
  property p_pwm_rise;
    $rose(pwm_output) |-> $changed(toggle_output) || period_match_irq;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise)
    else $error("pwm rose without trigger or period clear");
  property p_pwm_fall; $fell(pwm_output) |-> duty_match_irq
    || $past(req & wb_we_i) || $past(req & wb_we_i, 2); endproperty
  a_pwm_fall: assert property (p_pwm_fall)
    else $error("pwm fell without duty match");
  c_duty: cover property (duty_match_irq);
  c_per: cover property (period_match_irq);
  c_retrig: cover property ($fell(toggle_output) && pwm_output);
endmodule : tpwm_checker

bind tpwm_timer tpwm_checker chk_u (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_in(trig_in),
  .event_in(event_in), .toggle_output(toggle_output),
  .pwm_output(pwm_output), .period_match_irq(period_match_irq),
  .duty_match_irq(duty_match_irq));
`default_nettype wire

// [tpwm_edge.sv]
/*
  Shared constants for the triggered PWM timer, and the edge detector that
  the timer uses on its trigger and event inputs.
  Assumes that all inputs are already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

package tpwm_pkg;
  // Bus geometry and counter width
  localparam int          WB_AW          = 8;
  localparam int          WB_DW          = 32;
  localparam int          CW             = 16;

  // Register byte offsets
  localparam logic [7:0]  OFS_RUN        = 8'h00;
  localparam logic [7:0]  OFS_MODE       = 8'h04;
  localparam logic [7:0]  OFS_EDGE       = 8'h08;
  localparam logic [7:0]  OFS_PERIOD     = 8'h0c;
  localparam logic [7:0]  OFS_DUTY       = 8'h10;
  localparam logic [7:0]  OFS_COUNT      = 8'h14;
  localparam logic [7:0]  OFS_STATUS     = 8'h18;

  // Field positions
  localparam int          RUN_BIT        = 0;
  localparam int          MODE_LSB       = 0;
  localparam int          EEE_BIT        = 5;
  localparam int          EST_BIT        = 6;
  localparam int          TRIG_SEL_LSB   = 0;
  localparam int          EVT_SEL_LSB    = 2;
  localparam int          ST_ARM_BIT     = 0;
  localparam int          ST_PWM_BIT     = 1;
  localparam int          ST_TOG_BIT     = 2;
  localparam int          ST_WAIT_BIT    = 3;

  // Mode select encodings
  localparam logic [2:0]  MODE_EVENT     = 3'h1;
  localparam logic [2:0]  MODE_TRIG      = 3'h2;

  // Edge select encodings
  localparam logic [1:0]  EDGE_NONE      = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;

  // Values after reset, and the counter zero and one constants
  localparam logic [2:0]  MODE_RST       = 3'h0;
  localparam logic [1:0]  EDGE_RST       = 2'h0;
  localparam logic [15:0] CMP_RST        = 16'h0000;
  localparam logic [15:0] CNT_IDLE       = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;

  // Count clock divider default, in clk cycles per count step
  localparam int          COUNT_DIV_DEF  = 1;

  typedef enum logic [1:0] {
    TPWM_STOP,
    TPWM_WAIT,
    TPWM_RUN
  } tpwm_state_e;
endpackage : tpwm_pkg

module tpwm_edge_det (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sig_in,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);
  import tpwm_pkg::*;

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = sig_in;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // Both-edge select is the union of the two single-edge selects
  assign edge_pulse = (edge_sel[0] & sig_in & ~prev_reg) |
                      (edge_sel[1] & ~sig_in & prev_reg);
endmodule : tpwm_edge_det

`default_nettype wire

// [tpwm_far_end.sv]
/*
  Far-side source for the trigger and event pins.
  Assumes both-edge selection: each request flips a pin, one edge each.
*/
`timescale 1ns/1ps
`default_nettype none
module tpwm_far_end (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trig_req,
  input  wire logic evt_req,
  output logic      trig_in,
  output logic      event_in
);
  logic trig_reg, trig_next, evt_reg, evt_next;
  always_comb begin
    trig_next = trig_reg ^ trig_req;
    evt_next  = evt_reg ^ evt_req;
  end
  always_ff @(posedge clk) begin
    trig_reg <= rst ? 1'b0 : trig_next;
    evt_reg  <= rst ? 1'b0 : evt_next;
  end
  assign trig_in  = trig_reg;
  assign event_in = evt_reg;
endmodule : tpwm_far_end
`default_nettype wire

// [tpwm_timer.sv]
/*
  Triggered PWM timer channel: external event count mode and external
  trigger pulse output mode, registers on a classic Wishbone slave.
  Assumes trig_in and event_in are synchronous to clk, and that software
  keeps the programming order for the compare registers.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Event count: clear counter, pulse period match after period+1 edges.
// - Event count: period write goes to its shadow at once.
// - Counter above new period wraps through FFFFH before matching.
// - Duty below period: one duty match pulse per counter cycle.
// - Duty above period: the duty match never fires.
// - Mode select 010 picks trigger pulse output mode.
// - Run bit set waits; counting and PWM start at a trigger.
// - First trigger moves counter FFFFH to 0000H and counts on.
// - Trigger while running clears counter and restarts; never ignored.
// - Every trigger inverts toggle output and drives PWM high.
// - Soft triggers give toggle square wave, half period one PWM cycle.
// - PWM high for duty counts in a period of period+1 counts; high all period if duty exceeds period.
// - Period match pulses on the step after match, counter cleared.
// - Duty match pulses once as the counter steps onto the duty shadow.
// - Compare values move to shadows at the period clear.
// - Trigger is the chosen trigger edge or a soft trigger write.
// - Edge select register holds trigger and event edge fields.
// - Only a duty register write arms the shadow transfer.
module tpwm_timer #(
  parameter int COUNT_DIV = tpwm_pkg::COUNT_DIV_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [tpwm_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [tpwm_pkg::WB_DW-1:0] wb_dat_i,
  output logic      [tpwm_pkg::WB_DW-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      trig_in,
  input  wire logic                      event_in,
  output logic                           toggle_output,
  output logic                           pwm_output,
  output logic                           period_match_irq,
  output logic                           duty_match_irq
);
  import tpwm_pkg::*;

  // Refused at elaboration: the divider counts in 16 bits
  if (COUNT_DIV < 1 || COUNT_DIV > 65536) begin : g_bad_div
    $error("COUNT_DIV must lie in 1..65536");
  end

  localparam logic [15:0] DIV_LAST = 16'(COUNT_DIV - 1);

  // Bus and software-visible registers
  logic              ack_reg,      ack_next;
  logic [WB_DW-1:0]  dat_reg,      dat_next;
  logic              run_reg,      run_next;
  logic [2:0]        mode_reg,     mode_next;
  logic              eee_reg,      eee_next;
  logic [1:0]        trig_sel_reg, trig_sel_next;
  logic [1:0]        evt_sel_reg,  evt_sel_next;
  logic [CW-1:0]     per_cmp_reg,  per_cmp_next;
  logic [CW-1:0]     duty_cmp_reg, duty_cmp_next;

  // Counter group
  tpwm_state_e       state_reg,    state_next;
  logic [CW-1:0]     cnt_reg,      cnt_next;
  logic [CW-1:0]     per_sh_reg,   per_sh_next;
  logic [CW-1:0]     duty_sh_reg,  duty_sh_next;
  logic              arm_reg,      arm_next;
  logic              pwm_reg,      pwm_next;
  logic              tog_reg,      tog_next;
  logic              pirq_reg,     pirq_next;
  logic              dirq_reg,     dirq_next;
  logic [15:0]       div_reg,      div_next;

  logic              req;
  logic              wr;
  logic              period_wr;
  logic              duty_wr;
  logic              soft_trig;
  logic              trig_edge;
  logic              evt_edge;
  logic              div_tick;
  logic              step;
  logic              trigger;
  logic              cleared;
  logic [CW-1:0]     cnt_inc;
  logic [3:0]        status;

  function automatic logic [CW-1:0] merge16(input logic [CW-1:0] old,
                                            input logic [WB_DW-1:0] d,
                                            input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  tpwm_edge_det u_trig_edge (
    .clk        (clk),
    .rst        (rst),
    .sig_in     (trig_in),
    .edge_sel   (trig_sel_reg),
    .edge_pulse (trig_edge)
  );

  tpwm_edge_det u_evt_edge (
    .clk        (clk),
    .rst        (rst),
    .sig_in     (event_in),
    .edge_sel   (evt_sel_reg),
    .edge_pulse (evt_edge)
  );

  // One access per request; ack comes the cycle after the request is seen
  assign req       = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr        = req & wb_we_i;
  assign period_wr = wr && (wb_adr_i == OFS_PERIOD) && (wb_sel_i[1:0] != 2'h0);
  assign duty_wr   = wr && (wb_adr_i == OFS_DUTY) && (wb_sel_i[1:0] != 2'h0);
  assign soft_trig = wr && (wb_adr_i == OFS_MODE) && wb_sel_i[0] &&
                     wb_dat_i[EST_BIT];
  assign status    = {(state_reg == TPWM_WAIT), tog_reg, pwm_reg, arm_reg};

  always_comb begin
    ack_next      = req;
    dat_next      = dat_reg;
    run_next      = run_reg;
    mode_next     = mode_reg;
    eee_next      = eee_reg;
    trig_sel_next = trig_sel_reg;
    evt_sel_next  = evt_sel_reg;
    per_cmp_next  = per_cmp_reg;
    duty_cmp_next = duty_cmp_reg;
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        OFS_RUN: begin
          run_next = wb_dat_i[RUN_BIT];
        end
        OFS_MODE: begin
          mode_next = wb_dat_i[MODE_LSB +: 3];
          eee_next  = wb_dat_i[EEE_BIT];
        end
        OFS_EDGE: begin
          trig_sel_next = wb_dat_i[TRIG_SEL_LSB +: 2];
          evt_sel_next  = wb_dat_i[EVT_SEL_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
    if (period_wr) begin
      per_cmp_next = merge16(per_cmp_reg, wb_dat_i, wb_sel_i);
    end
    if (duty_wr) begin
      duty_cmp_next = merge16(duty_cmp_reg, wb_dat_i, wb_sel_i);
    end
    if (req) begin
      dat_next = '0;
      case (wb_adr_i)
        OFS_RUN:    dat_next[RUN_BIT] = run_reg;
        OFS_MODE: begin
          dat_next[MODE_LSB +: 3] = mode_reg;
          dat_next[EEE_BIT]       = eee_reg;
        end
        OFS_EDGE: begin
          dat_next[TRIG_SEL_LSB +: 2] = trig_sel_reg;
          dat_next[EVT_SEL_LSB +: 2]  = evt_sel_reg;
        end
        OFS_PERIOD: dat_next[CW-1:0] = per_cmp_reg;
        OFS_DUTY:   dat_next[CW-1:0] = duty_cmp_reg;
        OFS_COUNT:  dat_next[CW-1:0] = cnt_reg;
        OFS_STATUS: dat_next[3:0]    = status;
        default:    dat_next         = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg      <= 1'b0;
      dat_reg      <= '0;
      run_reg      <= 1'b0;
      mode_reg     <= MODE_RST;
      eee_reg      <= 1'b0;
      trig_sel_reg <= EDGE_RST;
      evt_sel_reg  <= EDGE_RST;
      per_cmp_reg  <= CMP_RST;
      duty_cmp_reg <= CMP_RST;
    end else begin
      ack_reg      <= ack_next;
      dat_reg      <= dat_next;
      run_reg      <= run_next;
      mode_reg     <= mode_next;
      eee_reg      <= eee_next;
      trig_sel_reg <= trig_sel_next;
      evt_sel_reg  <= evt_sel_next;
      per_cmp_reg  <= per_cmp_next;
      duty_cmp_reg <= duty_cmp_next;
    end
  end

  // Count clock divider stands in for the prescaler, which is left out
  assign div_tick = (div_reg == DIV_LAST);
  assign step     = (mode_reg == MODE_EVENT || eee_reg) ? evt_edge
                                                         : div_tick;
  assign trigger  = trig_edge | soft_trig;
  assign cnt_inc  = cnt_reg + CNT_ONE;

  always_comb begin
    div_next = div_tick ? 16'h0000 : div_reg + 16'h0001;
  end

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    per_sh_next  = per_sh_reg;
    duty_sh_next = duty_sh_reg;
    pwm_next     = pwm_reg;
    tog_next     = tog_reg;
    pirq_next    = 1'b0;
    dirq_next    = 1'b0;
    cleared      = 1'b0;
    case (state_reg)
      TPWM_STOP: begin
        cnt_next = CNT_IDLE;
        pwm_next = 1'b0;
        tog_next = 1'b0;
        if (run_reg) begin
          per_sh_next  = per_cmp_reg;
          duty_sh_next = duty_cmp_reg;
          if (mode_reg == MODE_EVENT) begin
            cnt_next   = CNT_ZERO;
            state_next = TPWM_RUN;
          end else if (mode_reg == MODE_TRIG) begin
            state_next = TPWM_WAIT;
          end
        end
      end
      TPWM_WAIT: begin
        if (trigger) begin
          cnt_next   = CNT_ZERO;
          tog_next   = ~tog_reg;
          pwm_next   = 1'b1;
          state_next = TPWM_RUN;
        end
      end
      TPWM_RUN: begin
        // A trigger beats a same-cycle match: that match pulse is dropped
        if (mode_reg == MODE_TRIG && trigger) begin
          cnt_next = CNT_ZERO;
          tog_next = ~tog_reg;
          pwm_next = 1'b1;
        end else if (step) begin
          if (cnt_reg == per_sh_reg) begin
            cnt_next  = CNT_ZERO;
            pirq_next = 1'b1;
            cleared   = 1'b1;
            if (arm_reg) begin
              per_sh_next  = per_cmp_reg;
              duty_sh_next = duty_cmp_reg;
            end
            dirq_next = (duty_sh_next == CNT_ZERO);
            pwm_next  = (mode_reg == MODE_TRIG) &&
                        (duty_sh_next != CNT_ZERO);
          end else begin
            cnt_next = cnt_inc;
            if (cnt_inc == duty_sh_reg) begin
              dirq_next = 1'b1;
              pwm_next  = 1'b0;
            end
          end
        end
      end
      default: begin
        state_next = TPWM_STOP;
      end
    endcase
    // Event count mode has no deferred period update
    if (period_wr && mode_reg == MODE_EVENT) begin
      per_sh_next = per_cmp_next;
    end
    if (!run_reg) begin
      state_next = TPWM_STOP;
      cnt_next   = CNT_IDLE;
      pwm_next   = 1'b0;
      tog_next   = 1'b0;
      pirq_next  = 1'b0;
      dirq_next  = 1'b0;
    end
  end

  // Arming: a duty write in the clearing cycle still arms the next transfer
  always_comb begin
    arm_next = duty_wr ? 1'b1 : (cleared ? 1'b0 : arm_reg);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= TPWM_STOP;
      cnt_reg     <= CNT_IDLE;
      per_sh_reg  <= CMP_RST;
      duty_sh_reg <= CMP_RST;
      arm_reg     <= 1'b0;
      pwm_reg     <= 1'b0;
      tog_reg     <= 1'b0;
      pirq_reg    <= 1'b0;
      dirq_reg    <= 1'b0;
      div_reg     <= 16'h0000;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      per_sh_reg  <= per_sh_next;
      duty_sh_reg <= duty_sh_next;
      arm_reg     <= arm_next;
      pwm_reg     <= pwm_next;
      tog_reg     <= tog_next;
      pirq_reg    <= pirq_next;
      dirq_reg    <= dirq_next;
      div_reg     <= div_next;
    end
  end

  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = dat_reg;
  assign toggle_output    = tog_reg;
  assign pwm_output       = pwm_reg;
  assign period_match_irq = pirq_reg;
  assign duty_match_irq   = dirq_reg;
endmodule : tpwm_timer

`default_nettype wire
